// ===== shared/bps_defs.svh
// Purpose: Constants of the board power sequencer.
// Assumes: 100 MHz core clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define BPS_CLK_MHZ 100
`define BPS_DEBOUNCE_MS 20
`define BPS_RELEASE_MS 200
`define BPS_ASSERT_US 32
`define BPS_BREAKER_US 20
`define BPS_DEBOUNCE_CYC (`BPS_DEBOUNCE_MS * 1000 * `BPS_CLK_MHZ)
`define BPS_RELEASE_CYC (`BPS_RELEASE_MS * 1000 * `BPS_CLK_MHZ)
`define BPS_ASSERT_CYC (`BPS_ASSERT_US * `BPS_CLK_MHZ)
`define BPS_BREAKER_CYC (`BPS_BREAKER_US * `BPS_CLK_MHZ)

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define BPS_REG_CTRL 12'h000
`define BPS_REG_STATUS 12'h004
`define BPS_REG_INT_STS 12'h008
`define BPS_REG_INT_EN 12'h00c
`define BPS_REG_INT_CLR 12'h010
`define BPS_CTRL_ENABLE 0
`define BPS_CTRL_CYCLE 1
`define BPS_CTRL_RESET 2'h1
`define BPS_INT_W 5
`define BPS_INT_FAULT 0
`define BPS_INT_PG_RISE 1
`define BPS_INT_PG_FALL 2
`define BPS_INT_REMOVAL 3
`define BPS_INT_CYCLE 4

// ----------------------------------------
// Synchronised pin positions
// ----------------------------------------
`define BPS_PIN_W 9
`define BPS_PIN_CON_A 0
`define BPS_PIN_CON_B 1
`define BPS_PIN_CYC 2
`define BPS_PIN_LO_SUP 3
`define BPS_PIN_HI_SUP 4
`define BPS_PIN_OUT_OK 5
`define BPS_PIN_TRIP 6
`define BPS_PIN_OC_LO 7
`define BPS_PIN_OC_HI 8

`endif

// ===== shared/bps_pkg.sv
// Purpose: Types of the board power sequencer.
// Assumes: Nothing beyond the header constants.
// Notes: One-hot state codes.
`default_nettype none
package bps_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ON    = 4'h2,
    ST_FAULT = 4'h4,
    ST_CYCLE = 4'h8
  } bps_state_t;
endpackage
`default_nettype wire

// ===== hw/bps_qual_timer.sv
// Purpose: Qualifies a level that must hold for more than a set time.
// Assumes: Input already synchronous to clock.
// Notes: Output is registered and drops one cycle after the level drops.
`default_nettype none
module bps_qual_timer #(
  parameter int CYCLES = 2000
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cond,
  output logic hit
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_ff;
  logic hit_ff;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= '0;
    end
    else if (!cond)
    begin
      cnt_ff <= '0;
    end
    else if (cnt_ff != W'(CYCLES))
    begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Hit once the level has outlasted the full count.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hit_ff <= 1'b0;
    end
    else
    begin
      hit_ff <= cond && (cnt_ff == W'(CYCLES));
    end
  end

  assign hit = hit_ff;
endmodule
`default_nettype wire

// ===== hw/bps_sequencer.sv
// Purpose: Sequencing logic of a board insertion power controller.
// Assumes: Comparator results arrive as asynchronous logic levels.
// Notes: APB slave with zero wait states; one level interrupt.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`include "bps_defs.svh"
`default_nettype none

module bps_sequencer #(
  parameter int DEBOUNCE_CYC = `BPS_DEBOUNCE_CYC,
  parameter int RELEASE_CYC = `BPS_RELEASE_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic connect_sense_a_n,
  input wire logic connect_sense_b_n,
  input wire logic power_cycle_n,
  input wire logic low_rail_supply_ok,
  input wire logic high_rail_supply_ok,
  input wire logic low_rail_output_ok,
  input wire logic outputs_below_trip,
  input wire logic low_rail_overcurrent,
  input wire logic high_rail_overcurrent,
  output logic low_rail_gate_drive,
  output logic high_rail_gate_drive,
  output logic gate_pulldown,
  output logic ramp_ref_on,
  output logic pump_on_indicator,
  output logic supply_ok_flag,
  output logic reset_out_n,
  output logic bus_isolate,
  output logic fault_n,
  output logic irq,
  output bps_pkg::bps_state_t state
);
  import bps_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [`BPS_PIN_W-1:0] pin_raw;
  logic [`BPS_PIN_W-1:0] sync1_ff;
  logic [`BPS_PIN_W-1:0] sync2_ff;
  logic conn_hit, cyc_hit, short_hit, rise_hit, fall_hit;
  logic cyc_hit_q_ff, cycle_req, sup_ok, out_ok_s;
  bps_state_t st_ff, nxt_st;
  logic from_fault_ff;
  logic pumps_ff, pulldown_ff, fault_n_ff, pg_ff, rst_n_ff, isolate_ff;
  logic [1:0] ctrl_ff;
  logic soft_cycle_ff;
  logic [`BPS_INT_W-1:0] int_sts_ff, int_en_ff, int_evt, int_clr;
  logic irq_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic wr_acc;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pin_raw = {high_rail_overcurrent, low_rail_overcurrent, outputs_below_trip,
                    low_rail_output_ok, high_rail_supply_ok, low_rail_supply_ok,
                    power_cycle_n, connect_sense_b_n, connect_sense_a_n};

  // Two flip-flops per asynchronous pin.
  genvar gi;
  generate
    for (gi = 0; gi < `BPS_PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end
        else
        begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  assign sup_ok = sync2_ff[`BPS_PIN_LO_SUP] && sync2_ff[`BPS_PIN_HI_SUP];
  assign out_ok_s = sync2_ff[`BPS_PIN_OUT_OK];

  // ----------------------------------------
  // Qualifying timers
  // ----------------------------------------
  // both senses low
  bps_qual_timer #(.CYCLES(DEBOUNCE_CYC)) u_conn (
    .clock(clock), .nrst(nrst),
    .cond(!sync2_ff[`BPS_PIN_CON_A] && !sync2_ff[`BPS_PIN_CON_B]), .hit(conn_hit));
  bps_qual_timer #(.CYCLES(DEBOUNCE_CYC)) u_cyc (
    .clock(clock), .nrst(nrst), .cond(!sync2_ff[`BPS_PIN_CYC]), .hit(cyc_hit));
  bps_qual_timer #(.CYCLES(`BPS_BREAKER_CYC)) u_brk (
    .clock(clock), .nrst(nrst),
    .cond(sync2_ff[`BPS_PIN_OC_LO] || sync2_ff[`BPS_PIN_OC_HI]), .hit(short_hit));
  bps_qual_timer #(.CYCLES(RELEASE_CYC)) u_rise (
    .clock(clock), .nrst(nrst), .cond(out_ok_s), .hit(rise_hit));
  bps_qual_timer #(.CYCLES(`BPS_ASSERT_CYC)) u_fall (
    .clock(clock), .nrst(nrst), .cond(!out_ok_s), .hit(fall_hit));

  // Edge of the qualified request, so a held request acts only once.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cyc_hit_q_ff <= 1'b0;
    end
    else
    begin
      cyc_hit_q_ff <= cyc_hit;
    end
  end

  assign cycle_req = (cyc_hit && !cyc_hit_q_ff) || soft_cycle_ff;

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  // Next state from qualified events and synchronised pin levels; a short outranks a cycle request.
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE:
        if (conn_hit && sup_ok && ctrl_ff[`BPS_CTRL_ENABLE])
          nxt_st = ST_ON;
      ST_ON:
        if (short_hit)
          nxt_st = ST_FAULT;
        else if (cycle_req)
          nxt_st = ST_CYCLE;
        else if (!conn_hit || !sup_ok)
          nxt_st = ST_IDLE;
      ST_FAULT:
        if (cycle_req)
          nxt_st = ST_CYCLE;
      ST_CYCLE:
        if (sync2_ff[`BPS_PIN_TRIP] && (from_fault_ff || sync2_ff[`BPS_PIN_CYC]))
          nxt_st = ST_IDLE;
      default:
        nxt_st = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= ST_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Remembers that the current discharge clears a fault.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      from_fault_ff <= 1'b0;
    end
    else if (st_ff == ST_FAULT && nxt_st == ST_CYCLE)
    begin
      from_fault_ff <= 1'b1;
    end
    else if (nxt_st != ST_CYCLE)
    begin
      from_fault_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Gate drive and flags
  // ----------------------------------------
  // pumps only in the on state
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pumps_ff <= 1'b0;
      pulldown_ff <= 1'b1;
    end
    else
    begin
      pumps_ff <= (nxt_st == ST_ON);
      pulldown_ff <= (nxt_st != ST_ON);
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      fault_n_ff <= 1'b1;
    end
    else if (st_ff == ST_ON && nxt_st == ST_FAULT)
    begin
      fault_n_ff <= 1'b0;
    end
    else if (st_ff == ST_FAULT && cycle_req)
    begin
      fault_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pg_ff <= 1'b0;
    end
    else
    begin
      pg_ff <= out_ok_s;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_n_ff <= 1'b0;
      isolate_ff <= 1'b1;
    end
    else if (fall_hit)
    begin
      rst_n_ff <= 1'b0;
      isolate_ff <= 1'b1;
    end
    else if (rise_hit && st_ff == ST_ON)
    begin
      rst_n_ff <= 1'b1;
      isolate_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign int_evt[`BPS_INT_FAULT] = (st_ff == ST_ON) && (nxt_st == ST_FAULT);
  assign int_evt[`BPS_INT_PG_RISE] = out_ok_s && !pg_ff;
  assign int_evt[`BPS_INT_PG_FALL] = !out_ok_s && pg_ff;
  assign int_evt[`BPS_INT_REMOVAL] = (st_ff == ST_ON) && (nxt_st == ST_IDLE);
  assign int_evt[`BPS_INT_CYCLE] = (nxt_st == ST_CYCLE) && (st_ff != ST_CYCLE);
  assign int_clr = (wr_acc && paddr == `BPS_REG_INT_CLR) ? pwdata[`BPS_INT_W-1:0] : '0;

  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      int_sts_ff <= '0;
    end
    else
    begin
      int_sts_ff <= (int_sts_ff & ~int_clr) | int_evt;
    end
  end

  // Level interrupt from enabled status bits.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= |(int_sts_ff & int_en_ff);
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr_acc = psel && penable && pready_ff && pwrite;

  // Writable registers; the cycle bit is a one-cycle command.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_ff <= `BPS_CTRL_RESET;
      int_en_ff <= '0;
      soft_cycle_ff <= 1'b0;
    end
    else
    begin
      soft_cycle_ff <= wr_acc && paddr == `BPS_REG_CTRL && pwdata[`BPS_CTRL_CYCLE];
      if (wr_acc && paddr == `BPS_REG_CTRL)
        ctrl_ff <= {1'b0, pwdata[`BPS_CTRL_ENABLE]};
      if (wr_acc && paddr == `BPS_REG_INT_EN)
        int_en_ff <= pwdata[`BPS_INT_W-1:0];
    end
  end

  // Answer prepared in the setup cycle, presented in the access cycle.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= psel && !penable;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      if (psel && !penable)
      begin
        unique case (paddr)
          `BPS_REG_CTRL: prdata_ff <= {30'h0, ctrl_ff};
          `BPS_REG_STATUS: prdata_ff <= {22'h0, fault_n_ff, rst_n_ff, isolate_ff,
                                         pg_ff, pumps_ff, from_fault_ff, st_ff};
          `BPS_REG_INT_STS: prdata_ff <= {27'h0, int_sts_ff};
          `BPS_REG_INT_EN: prdata_ff <= {27'h0, int_en_ff};
          `BPS_REG_INT_CLR: prdata_ff <= '0;
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign low_rail_gate_drive = pumps_ff;
  assign high_rail_gate_drive = pumps_ff;
  assign ramp_ref_on = pumps_ff;
  assign pump_on_indicator = pumps_ff;
  assign gate_pulldown = pulldown_ff;
  assign fault_n = fault_n_ff;
  assign supply_ok_flag = pg_ff;
  assign reset_out_n = rst_n_ff;
  assign bus_isolate = isolate_ff;
  assign irq = irq_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign state = st_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_short_in_on;
    st_ff == ST_ON && short_hit;
  endsequence

  sequence s_off_drive;
    !pumps_ff && pulldown_ff;
  endsequence

  a_isolate_tracks_reset: assert property (isolate_ff != rst_n_ff)
    else $error("isolation not inverse of reset");
  a_start_after_debounce: assert property ($rose(pumps_ff) |-> $past(conn_hit))
    else $error("pumps started without debounced connection");
  a_pumps_need_supply: assert property ($rose(pumps_ff) |-> $past(sup_ok))
    else $error("pumps started under lockout");
  a_flag_follows_out: assert property ($rose(out_ok_s) |=> $rose(pg_ff))
    else $error("supply-ok flag late");
  a_release_needs_hold: assert property ($rose(rst_n_ff) |-> $past(rise_hit))
    else $error("reset released early");
  a_cycle_pulls_down: assert property (
    (st_ff == ST_ON && !short_hit && cycle_req) |=> s_off_drive ##1 s_off_drive)
    else $error("power cycle did not pull gates down");
  a_reset_fall_delay: assert property ($fell(rst_n_ff) |-> $past(fall_hit))
    else $error("reset asserted without delay");
  a_request_holds_off: assert property (
    (st_ff == ST_CYCLE && !from_fault_ff && !sync2_ff[`BPS_PIN_CYC])
      |=> st_ff == ST_CYCLE)
    else $error("left discharge while request low");
  a_fault_stays: assert property ((st_ff == ST_FAULT && !cycle_req) |=> st_ff == ST_FAULT)
    else $error("fault cleared without request");
  a_short_trips: assert property (s_short_in_on |=> s_off_drive and (!fault_n_ff))
    else $error("short did not trip breaker");
  a_irq_level: assert property ((|(int_sts_ff & int_en_ff)) |=> irq_ff)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// ===== tb/bps_host_model.sv
// Purpose: Backplane side of the sequencer: sense pins, cycle request, rail comparators.
// Assumes: Bench commands plug, cycle request and short as plain levels.
// Notes: Rails are a small level count that ramps with the gates.
`default_nettype none
module bps_host_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic plugged,
  input wire logic cycle_req,
  input wire logic short_on,
  input wire logic low_rail_gate_drive,
  input wire logic high_rail_gate_drive,
  input wire logic gate_pulldown,
  output logic connect_sense_a_n,
  output logic connect_sense_b_n,
  output logic power_cycle_n,
  output logic low_rail_supply_ok,
  output logic high_rail_supply_ok,
  output logic low_rail_output_ok,
  output logic outputs_below_trip,
  output logic low_rail_overcurrent,
  output logic high_rail_overcurrent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lo_lvl_ff;
  logic [3:0] hi_lvl_ff;

  // Unplugged sense pins float to their pull-up level.
  assign connect_sense_a_n = ~plugged;
  assign connect_sense_b_n = ~plugged;
  assign power_cycle_n = ~cycle_req;
  assign low_rail_supply_ok = plugged;
  assign high_rail_supply_ok = plugged;
  assign low_rail_output_ok = (lo_lvl_ff >= 4'ha);
  assign outputs_below_trip = (lo_lvl_ff == 4'h0) && (hi_lvl_ff == 4'h0);
  assign low_rail_overcurrent = short_on & low_rail_gate_drive;
  assign high_rail_overcurrent = 1'b0;

  // Low rail ramps up with its gate and discharges through the pulldown.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      lo_lvl_ff <= 4'h0;
    else if (low_rail_gate_drive && lo_lvl_ff != 4'hf)
      lo_lvl_ff <= lo_lvl_ff + 4'h1;
    else if (!low_rail_gate_drive && gate_pulldown && lo_lvl_ff != 4'h0)
      lo_lvl_ff <= lo_lvl_ff - 4'h1;
  end

  // High rail follows its own gate in the same way.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hi_lvl_ff <= 4'h0;
    else if (high_rail_gate_drive && hi_lvl_ff != 4'hf)
      hi_lvl_ff <= hi_lvl_ff + 4'h1;
    else if (!high_rail_gate_drive && gate_pulldown && hi_lvl_ff != 4'h0)
      hi_lvl_ff <= hi_lvl_ff - 4'h1;
  end
endmodule
`default_nettype wire

// ===== tb/bps_sequencer_bench.sv
// Purpose: Self-checking bench of the board power sequencer.
// Assumes: Short debounce and release counts; fixed 32 us and 20 us delays.
// Notes: Scenarios run in order and each leaves the board powered or idle.
`include "bps_defs.svh"
`default_nettype none
module bps_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bps_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, plugged = 1'b0, cycle_req = 1'b0, short_on = 1'b0;
  logic sa_n, sb_n, pc_n, lo_ok, hi_ok, out_ok, below, oc_lo, oc_hi;
  logic gate_lo, gate_hi, gate_pulldown, ramp_ref_on, pump_on_indicator;
  logic supply_ok_flag, reset_out_n, bus_isolate, fault_n, irq;
  bps_state_t state;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;

  // ----------------------------------------
  // Clock, timeout and instances
  // ----------------------------------------
  always #5 clock = ~clock;

  // A hang ends the run as a failure.
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  bps_sequencer #(.DEBOUNCE_CYC(20), .RELEASE_CYC(50)) i_bps_sequencer (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .connect_sense_a_n(sa_n), .connect_sense_b_n(sb_n), .power_cycle_n(pc_n),
    .low_rail_supply_ok(lo_ok), .high_rail_supply_ok(hi_ok), .low_rail_output_ok(out_ok),
    .outputs_below_trip(below), .low_rail_overcurrent(oc_lo), .high_rail_overcurrent(oc_hi),
    .low_rail_gate_drive(gate_lo), .high_rail_gate_drive(gate_hi),
    .gate_pulldown(gate_pulldown), .ramp_ref_on(ramp_ref_on),
    .pump_on_indicator(pump_on_indicator), .supply_ok_flag(supply_ok_flag),
    .reset_out_n(reset_out_n), .bus_isolate(bus_isolate), .fault_n(fault_n),
    .irq(irq), .state(state));

  bps_host_model i_bps_host_model (
    .clock(clock), .nrst(nrst), .plugged(plugged), .cycle_req(cycle_req),
    .short_on(short_on), .low_rail_gate_drive(gate_lo), .high_rail_gate_drive(gate_hi),
    .gate_pulldown(gate_pulldown), .connect_sense_a_n(sa_n), .connect_sense_b_n(sb_n),
    .power_cycle_n(pc_n), .low_rail_supply_ok(lo_ok), .high_rail_supply_ok(hi_ok),
    .low_rail_output_ok(out_ok), .outputs_below_trip(below),
    .low_rail_overcurrent(oc_lo), .high_rail_overcurrent(oc_hi));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %b", $time, msg, got);
    end
  endtask

  task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h", $time, msg, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  // An idle edge follows, so back-to-back calls never drive psel twice in one step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_up();
    int n;
    plugged <= 1'b1;
    wt(15);
    chk(pump_on_indicator, 1'b0, "pumps before debounce");
    n = 0;
    while (pump_on_indicator !== 1'b1 && n < 40) begin @(posedge clock); n++; end
    chk(pump_on_indicator, 1'b1, "pumps on");
    chk(ramp_ref_on, 1'b1, "ramp reference");
    chk(gate_lo && gate_hi, 1'b1, "both gates on");
    n = 0;
    while (supply_ok_flag !== 1'b1 && n < 30) begin @(posedge clock); n++; end
    chk(supply_ok_flag, 1'b1, "supply ok rise");
    wt(40);
    chk(reset_out_n, 1'b0, "reset early release");
    n = 0;
    while (reset_out_n !== 1'b1 && n < 30) begin @(posedge clock); n++; end
    chk(reset_out_n, 1'b1, "reset release");
    chk(bus_isolate, 1'b0, "bus enabled");
    chk(irq, 1'b1, "irq on supply ok rise");
    apb(1'b0, `BPS_REG_INT_STS, 32'h0);
    chkw(rd & 32'h2, 32'h2, "pg rise status");
    apb(1'b1, `BPS_REG_INT_CLR, 32'h1f);
    wt(3);
    chk(irq, 1'b0, "irq cleared");
    apb(1'b0, `BPS_REG_STATUS, 32'h0);
    chkw(rd & 32'h10f, 32'h100 | 32'(ST_ON), "status on");
    $display("test power_up done");
  endtask

  task automatic t_cycle();
    int n;
    cycle_req <= 1'b1;
    wt(10);
    cycle_req <= 1'b0;
    wt(40);
    chk(pump_on_indicator, 1'b1, "short pulse ignored");
    cycle_req <= 1'b1;
    n = 0;
    while (pump_on_indicator !== 1'b0 && n < 40) begin @(posedge clock); n++; end
    chk(pump_on_indicator, 1'b0, "cycle pumps off");
    chk(gate_pulldown, 1'b1, "cycle pulldown");
    n = 0;
    while (supply_ok_flag !== 1'b0 && n < 30) begin @(posedge clock); n++; end
    chk(supply_ok_flag, 1'b0, "supply ok drop");
    wt(3100);
    chk(reset_out_n, 1'b1, "reset held before delay");
    wt(200);
    chk(reset_out_n, 1'b0, "reset asserted");
    chk(bus_isolate, 1'b1, "bus isolated");
    wt(100);
    chk(pump_on_indicator, 1'b0, "held while request low");
    cycle_req <= 1'b0;
    n = 0;
    while (pump_on_indicator !== 1'b1 && n < 80) begin @(posedge clock); n++; end
    chk(pump_on_indicator, 1'b1, "automatic restart");
    wt(200);
    $display("test cycle done");
  endtask

  task automatic t_fault();
    int n;
    apb(1'b1, `BPS_REG_INT_EN, 32'h0);
    short_on <= 1'b1;
    wt(1900);
    chk(fault_n, 1'b1, "breaker too early");
    wt(300);
    chk(fault_n, 1'b0, "breaker tripped");
    chk(pump_on_indicator, 1'b0, "fault pumps off");
    chk(gate_pulldown, 1'b1, "fault pulldown");
    chkw(32'(state), 32'(ST_FAULT), "fault state");
    short_on <= 1'b0;
    wt(3);
    chk(irq, 1'b0, "masked irq");
    apb(1'b1, `BPS_REG_INT_EN, 32'h1);
    wt(3);
    chk(irq, 1'b1, "fault irq");
    cycle_req <= 1'b1;
    n = 0;
    while (fault_n !== 1'b1 && n < 80) begin @(posedge clock); n++; end
    chk(fault_n, 1'b1, "fault cleared");
    n = 0;
    while (pump_on_indicator !== 1'b1 && n < 40) begin @(posedge clock); n++; end
    chk(pump_on_indicator, 1'b1, "restart after fault");
    cycle_req <= 1'b0;
    apb(1'b1, `BPS_REG_INT_CLR, 32'h1f);
    wt(3);
    chk(irq, 1'b0, "fault irq cleared");
    apb(1'b1, `BPS_REG_CTRL, 32'h3);
    wt(2);
    chk(pump_on_indicator, 1'b0, "soft cycle pumps off");
    n = 0;
    while (pump_on_indicator !== 1'b1 && n < 60) begin @(posedge clock); n++; end
    chk(pump_on_indicator, 1'b1, "soft cycle restart");
    $display("test fault done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    wt(4);
    chk(bus_isolate, 1'b1, "isolated in reset");
    nrst <= 1'b1;
    wt(1);
    apb(1'b0, `BPS_REG_CTRL, 32'h0);
    chkw(rd & 32'h1, 32'h1, "ctrl reset value");
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chkw(rd, 32'h0, "unmapped data");
    apb(1'b1, `BPS_REG_INT_EN, 32'h1f);
    chk(bus_isolate, 1'b1, "isolated after reset");
    t_power_up();
    t_cycle();
    t_fault();
    plugged <= 1'b0;
    wt(10);
    chk(pump_on_indicator, 1'b0, "removal pumps off");
    $display("test removal done");
    wrap_up();
  end
endmodule
`default_nettype wire
